// File: pkg/bcdr_pkg.sv
/*
 * Package for the bridge control and diagnostic register bank.
 * Holds register offsets, field positions, reset values, write masks,
 * timing constants and the packed request carrier of the configuration port.
 * Assumes a single 50 MHz clock domain shared by every user of the package.
 */
package bcdr_pkg;

   // Configuration byte offsets of the two registers.
   localparam logic [7:0]  BCDR_CTRL_OFFSET       = 8'hC0;
   localparam logic [7:0]  BCDR_DIAG_OFFSET       = 8'hC4;

   // Control register field positions.
   localparam int          CTRL_THRESH_SEL_LSB    = 4;
   localparam int          CTRL_THRESH_EN_BIT     = 3;
   localparam int          CTRL_CFG_PATH_BIT      = 2;
   localparam int          CTRL_RSVD_RW_BIT       = 1;

   // Control register reset value and the bits that software may change.
   localparam logic [31:0] CTRL_RESET             = 32'h0000_0000;
   localparam logic [31:0] CTRL_WR_MASK           = 32'h0000_003E;

   // Diagnostic register field positions.
   localparam int          DIAG_SEP_LAT_LSB       = 18;
   localparam int          DIAG_SHR_LAT_LSB       = 15;
   localparam int          DIAG_RSVD_HI_LSB       = 11;
   localparam int          DIAG_SEC_BLOCK_BIT     = 10;
   localparam int          DIAG_DEEP_TMR_LSB      = 6;
   localparam int          DIAG_STBY_TMR_LSB      = 2;

   // Diagnostic register reset value and the bits that software may change.
   localparam logic [31:0] DIAG_RESET             = 32'h0012_0108;
   localparam logic [31:0] DIAG_WR_MASK           = 32'h001F_FFFF;

   // Threshold arithmetic; line and step sizes in dwords.
   localparam logic [7:0]  FALLBACK_LINE_DW       = 8'h08;
   localparam logic [9:0]  THRESH_STEP_DW         = 10'h004;
   localparam logic [1:0]  THRESH_SEL_TWO_LINES   = 2'h3;

   // Clock and timer tick figures, with derived cycle counts rounded up.
   localparam int          CLK_PERIOD_PS          = 20000;
   localparam int          DEEP_IDLE_TICK_PS      = 512000;
   localparam int          STANDBY_TICK_PS        = 16000;
   localparam int          DEEP_IDLE_TICK_CYC     =
      (DEEP_IDLE_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          STANDBY_TICK_CYC       =
      (STANDBY_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Width of the idle timer cycle counters.
   localparam int          TMR_CNT_W              = 10;

   // One configuration access as presented on the request port.
   typedef struct packed
   {
      logic        sel;
      logic        wr;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } bcdr_cfg_req_t;

endpackage

// File: hw/bcdr_regs.sv
/*
 * Control and diagnostic register bank of a serial-link to parallel-bus bridge.
 * Assumes configuration requests, strap inputs and link idle indications
 * are synchronous to CLOCK, and RST_B is the internal power-on reset.
 */
// Function
// - Threshold select picks buffer space needed.
// - Invalid cache line size counts as 8 DW.
// - Threshold enable bit, reset to off.
// - Config path bit opens mapped register access.
// - Control bit 1 resets zero, bit 0 reads zero.
// - Diagnostic register at C4h, resets 0012_0108h.
// - Diagnostic bits 31:21 read-only zero.
// - Common clock set mirrors separate-clock latency.
// - Common clock clear mirrors shared-clock latency.
// - Diagnostic bits 14:11 reset to zero.
// - Block bit suppresses secondary bus reset.
// - Deep idle timer counts 512 ns ticks; the code rounds each tick up to 26 cycles, 520 ns.
// - Standby timer counts 62.5 MHz ticks; the code rounds each tick up to one 20 ns clock.
// - Diagnostic bits 1:0 reset to zero.
// - Link, global and power-on reset restore defaults.
module bcdr_regs
   import bcdr_pkg::*;
(
   // Clock and resets.
   input  wire logic          CLOCK,
   input  wire logic          RST_B,
   input  wire logic          LINK_RESET_B,
   input  wire logic          GLOBAL_RESET_PIN_B,
   // Configuration access port.
   input  wire bcdr_cfg_req_t CFG_REQ,
   output logic               CFG_ACK,
   output logic [31:0]        CFG_RDATA,
   // Upstream buffer threshold.
   input  wire logic [7:0]    CACHE_LINE_SIZE,
   input  wire logic [9:0]    UP_FREE_DW,
   output logic [9:0]         UP_THRESH_DW,
   output logic               UP_THRESH_EN,
   output logic               UP_ACCEPT,
   // Configuration path to memory-mapped registers.
   output logic               CFG_MEM_ACCESS_EN,
   // Link capability exit latency.
   input  wire logic          COMMON_CLOCK_CONFIG_BIT,
   output logic [2:0]         LINK_CAP_EXIT_LATENCY,
   // Secondary bus reset.
   input  wire logic          SECONDARY_BUS_RESET_BIT,
   output logic               SEC_BUS_RESET,
   // Link power state entry timers.
   input  wire logic          LINK_IDLE,
   output logic               DEEP_IDLE_ENTRY_REQ,
   output logic               STANDBY_ENTRY_REQ
);

   // Stored register contents.
   logic [31:0]          ctrl_reg;        // Control register image.
   logic [31:0]          ctrl_next;       // Next control register image.
   logic [31:0]          diag_reg;        // Diagnostic register image.
   logic [31:0]          diag_next;       // Next diagnostic register image.
   logic [31:0]          rdata_next;      // Next read data.
   logic [9:0]           thresh_reg;      // Registered threshold in dwords.
   logic [9:0]           thresh_next;     // Computed threshold in dwords.
   logic [2:0]           exit_lat_reg;    // Registered mirrored exit latency.
   logic [2:0]           exit_lat_next;   // Selected exit latency.

   // Decoded access strobes.
   wire                  hit_ctrl;        // Request addresses the control register.
   wire                  hit_diag;        // Request addresses the diagnostic register.
   wire                  wr_ctrl;         // Write to the control register.
   wire                  wr_diag;         // Write to the diagnostic register.
   wire                  field_clear;     // Link or global reset restores defaults.
   wire [31:0]           lane_mask;       // Byte enables spread over bits.

   // Named fields of the stored registers.
   wire [1:0]            thresh_sel;      // Threshold select field.
   wire [2:0]            sep_exit_lat;    // Separate-clock exit latency.
   wire [2:0]            shr_exit_lat;    // Shared-clock exit latency.
   wire                  sec_block;       // Secondary reset block bit.
   wire [3:0]            deep_idle_entry_timer;  // Deep idle ticks.
   wire [3:0]            standby_entry_timer;    // Standby ticks.

   // Cache line handling for the threshold.
   wire                  line_valid;      // Cache line size is a usable value.
   wire [7:0]            line_dw;         // Cache line used for the threshold.
   wire [9:0]            line_dw_w;       // Cache line widened to threshold width.

   // Idle timers, entry 0 is deep idle and entry 1 is standby.
   wire [TMR_CNT_W-1:0]  tmr_limit [2];   // Timeout in clock cycles.
   logic [1:0]           tmr_fire;        // Timeout reached while idle.

   // Address decode compares the whole byte offset, so only aligned words hit.
   assign hit_ctrl    = CFG_REQ.sel && (CFG_REQ.addr == BCDR_CTRL_OFFSET);
   assign hit_diag    = CFG_REQ.sel && (CFG_REQ.addr == BCDR_DIAG_OFFSET);
   assign wr_ctrl     = hit_ctrl && CFG_REQ.wr;
   assign wr_diag     = hit_diag && CFG_REQ.wr;
   assign field_clear = !LINK_RESET_B || !GLOBAL_RESET_PIN_B;

   // Each byte enable covers its own eight data bits.
   genvar lane;
   generate
      for (lane = 0; lane < 4; lane++)
      begin : g_lane
         assign lane_mask[lane*8 +: 8] = {8{CFG_REQ.be[lane]}};
      end
   endgenerate

   // Field extraction from the stored images.
   assign thresh_sel            = ctrl_reg[CTRL_THRESH_SEL_LSB +: 2];
   assign sep_exit_lat          = diag_reg[DIAG_SEP_LAT_LSB +: 3];
   assign shr_exit_lat          = diag_reg[DIAG_SHR_LAT_LSB +: 3];
   assign sec_block             = diag_reg[DIAG_SEC_BLOCK_BIT];
   assign deep_idle_entry_timer = diag_reg[DIAG_DEEP_TMR_LSB +: 4];
   assign standby_entry_timer   = diag_reg[DIAG_STBY_TMR_LSB +: 4];

   // A cache line size is taken as valid when it is a nonzero power of two.
   // Any other size falls back to eight dwords so the threshold stays usable.
   assign line_valid = (CACHE_LINE_SIZE != 8'h00) &&
                       ((CACHE_LINE_SIZE & (CACHE_LINE_SIZE - 8'h01)) == 8'h00);
   assign line_dw    = line_valid ? CACHE_LINE_SIZE : FALLBACK_LINE_DW;
   assign line_dw_w  = {2'h0, line_dw};

   // Next control image: write-masked bytes merge with the old value.
   // Bit 0 and bits above 5 are outside the mask and stay zero.
   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl)
      begin
         // Only enabled lanes of writable bits change.
         ctrl_next = (ctrl_reg & ~(lane_mask & CTRL_WR_MASK)) |
                     (CFG_REQ.wdata & lane_mask & CTRL_WR_MASK);
      end
   end

   // Next diagnostic image: bits 31:21 never take written data.
   always_comb
   begin
      diag_next = diag_reg;
      if (wr_diag)
      begin
         // Reserved read-write bits store whatever is written, as documented.
         // Software is expected to write zero into bits 14:11 and 1:0.
         diag_next = (diag_reg & ~(lane_mask & DIAG_WR_MASK)) |
                     (CFG_REQ.wdata & lane_mask & DIAG_WR_MASK);
      end
   end

   // Threshold in dwords: one line plus 4, 8 or 12, or two lines plus 4.
   always_comb
   begin
      if (thresh_sel == THRESH_SEL_TWO_LINES)
      begin
         // Two whole cache lines and one step.
         thresh_next = (line_dw_w << 1) + THRESH_STEP_DW;
      end
      else
      begin
         // One cache line plus one to three steps.
         thresh_next = line_dw_w + THRESH_STEP_DW * {8'h00, thresh_sel + 2'h1};
      end
   end

   // Exit latency mirror follows the common clock configuration.
   always_comb
   begin
      if (COMMON_CLOCK_CONFIG_BIT)
      begin
         // Common clock set selects the separate-clock value.
         exit_lat_next = sep_exit_lat;
      end
      else
      begin
         // Common clock clear selects the shared-clock value.
         exit_lat_next = shr_exit_lat;
      end
   end

   // Read data: mapped registers return their image, others return zero.
   always_comb
   begin
      if (hit_ctrl)
      begin
         // Control register, bit 0 and bits 31:6 forced low.
         rdata_next = ctrl_reg & CTRL_WR_MASK;
      end
      else if (hit_diag)
      begin
         // Diagnostic register, upper bits forced low.
         rdata_next = diag_reg & DIAG_WR_MASK;
      end
      else
      begin
         // Unmapped offsets read as zero.
         rdata_next = 32'h0000_0000;
      end
   end

   // Register images: power-on reset asynchronously, link and global
   // reset synchronously, so both paths land on the same defaults.
   // A link or global reset wins over a write in the same cycle, so
   // software must wait for the reset to end before programming.
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         ctrl_reg <= CTRL_RESET;
         diag_reg <= DIAG_RESET;
      end
      else if (field_clear)
      begin
         ctrl_reg <= CTRL_RESET;
         diag_reg <= DIAG_RESET;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         diag_reg <= diag_next;
      end
   end

   // Answer to the configuration port, one cycle after the request.
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         CFG_ACK   <= 1'b0;
         CFG_RDATA <= 32'h0000_0000;
      end
      else
      begin
         CFG_ACK   <= CFG_REQ.sel;
         CFG_RDATA <= (CFG_REQ.sel && !CFG_REQ.wr) ? rdata_next : 32'h0000_0000;
      end
   end

   // Derived outputs are registered so they change one cycle after the register they follow, two cycles after a write request.
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         thresh_reg   <= 10'h000;
         exit_lat_reg <= 3'h0;
      end
      else
      begin
         thresh_reg   <= thresh_next;
         exit_lat_reg <= exit_lat_next;
      end
   end

   // Threshold outputs and the accept decision seen by the parallel bus.
   assign UP_THRESH_DW          = thresh_reg;
   assign UP_THRESH_EN          = ctrl_reg[CTRL_THRESH_EN_BIT];
   assign UP_ACCEPT             = !UP_THRESH_EN || (UP_FREE_DW >= thresh_reg);
   assign CFG_MEM_ACCESS_EN     = ctrl_reg[CTRL_CFG_PATH_BIT];
   assign LINK_CAP_EXIT_LATENCY = exit_lat_reg;

   // The block bit masks the bridge control reset request.
   assign SEC_BUS_RESET = SECONDARY_BUS_RESET_BIT && !sec_block;

   // Timeouts in clock cycles: field value times the tick length.
   // Tick lengths are rounded up to whole clock cycles, so a deep idle
   // tick lasts 520 ns and a standby tick one full 20 ns clock.
   assign tmr_limit[0] = TMR_CNT_W'(deep_idle_entry_timer * DEEP_IDLE_TICK_CYC);
   assign tmr_limit[1] = TMR_CNT_W'(standby_entry_timer * STANDBY_TICK_CYC);

   // Each idle timer counts cycles of continuous idle and then holds its
   // request until the link leaves idle. A zero field never requests entry,
   // so a cleared field switches that power state off.
   genvar t;
   generate
      for (t = 0; t < 2; t++)
      begin : g_tmr
         logic [TMR_CNT_W-1:0] cnt_reg;    // Idle cycles seen so far.
         logic [TMR_CNT_W-1:0] cnt_next;   // Next idle cycle count.
         wire                  reached;    // Count has met the timeout.

         assign reached     = (tmr_limit[t] != '0) && (cnt_reg >= tmr_limit[t]);
         assign cnt_next    = (!LINK_IDLE) ? '0 :
                              reached ? cnt_reg : cnt_reg + TMR_CNT_W'(1);
         assign tmr_fire[t] = LINK_IDLE && reached;

         // Counter restarts whenever the link is busy.
         always_ff @(posedge CLOCK or negedge RST_B)
         begin
            if (!RST_B)
            begin
               cnt_reg <= '0;
            end
            else
            begin
               cnt_reg <= cnt_next;
            end
         end
      end
   endgenerate

   // Entry requests toward the link power manager.
   assign DEEP_IDLE_ENTRY_REQ = tmr_fire[0];
   assign STANDBY_ENTRY_REQ   = tmr_fire[1];

endmodule // bcdr_regs

// File: dv/bcdr_regs_chk.sv
/* Port checker for the control and diagnostic register bank.
   Assumes one clock domain and is bound to every bcdr_regs instance. */
module bcdr_regs_chk
   import bcdr_pkg::*;
(
   // Clock and reset.
   input wire logic          CLOCK,
   input wire logic          RST_B,
   // Observed ports.
   input wire bcdr_cfg_req_t CFG_REQ,
   input wire logic          CFG_ACK,
   input wire logic [31:0]   CFG_RDATA,
   input wire logic [9:0]    UP_FREE_DW,
   input wire logic [9:0]    UP_THRESH_DW,
   input wire logic          UP_THRESH_EN,
   input wire logic          UP_ACCEPT,
   input wire logic          SECONDARY_BUS_RESET_BIT,
   input wire logic          SEC_BUS_RESET,
   input wire logic          LINK_IDLE,
   input wire logic          STANDBY_ENTRY_REQ,
   input wire logic          DEEP_IDLE_ENTRY_REQ
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   // A read request to one offset.
   sequence s_rd(logic [7:0] a);
      CFG_REQ.sel && !CFG_REQ.wr && CFG_REQ.addr == a;
   endsequence
   a_ack_follows_req: assert property (CFG_REQ.sel |=> CFG_ACK)
      else $error("acknowledge missing after a request");
   a_ack_needs_req: assert property (!CFG_REQ.sel |=> !CFG_ACK)
      else $error("acknowledge without a request");
   a_rdata_idle_zero: assert property (!CFG_ACK |-> CFG_RDATA == 32'h0)
      else $error("read data not zero outside acknowledge");
   a_diag_top_zero: assert property (s_rd(BCDR_DIAG_OFFSET) |=>
      CFG_RDATA[31:21] == 11'h000) else $error("diagnostic upper bits not zero");
   a_ctrl_fixed_zero: assert property (s_rd(BCDR_CTRL_OFFSET) |=>
      CFG_RDATA[31:6] == 26'h0 && !CFG_RDATA[0]) else $error("control fixed bits not zero");
   a_unmapped_read_zero: assert property (s_rd(8'hC8) |=> CFG_RDATA == 32'h0)
      else $error("unmapped read not zero");
   a_accept_gate: assert property (
      UP_ACCEPT == (!UP_THRESH_EN || UP_FREE_DW >= UP_THRESH_DW))
      else $error("accept does not follow threshold");
   a_sec_reset_gate: assert property (!SECONDARY_BUS_RESET_BIT |-> !SEC_BUS_RESET)
      else $error("secondary reset without its bit");
   a_idle_drop_req: assert property (!LINK_IDLE |->
      !STANDBY_ENTRY_REQ && !DEEP_IDLE_ENTRY_REQ) else $error("entry request while link busy");
endmodule // bcdr_regs_chk

bind bcdr_regs bcdr_regs_chk i_bcdr_regs_chk (.CLOCK(CLOCK), .RST_B(RST_B), .CFG_REQ(CFG_REQ),
   .CFG_ACK(CFG_ACK), .CFG_RDATA(CFG_RDATA), .UP_FREE_DW(UP_FREE_DW),
   .UP_THRESH_DW(UP_THRESH_DW), .UP_THRESH_EN(UP_THRESH_EN), .UP_ACCEPT(UP_ACCEPT),
   .SECONDARY_BUS_RESET_BIT(SECONDARY_BUS_RESET_BIT), .SEC_BUS_RESET(SEC_BUS_RESET),
   .LINK_IDLE(LINK_IDLE), .STANDBY_ENTRY_REQ(STANDBY_ENTRY_REQ),
   .DEEP_IDLE_ENTRY_REQ(DEEP_IDLE_ENTRY_REQ));

// File: dv/tb_bcdr_regs.sv
/* Self-checking bench for the control and diagnostic register bank.
   Assumes the bound checker and drives every input at or 1 ns after a falling edge. */
module tb_bcdr_regs
   import bcdr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Bench side of the ports.
   logic          clock, rst_b, lrst_b, global_reset_pin_b, ack, th_en, accept, mem_en;
   logic          ccc, sbr, sec, idle, deep, stby;
   logic [31:0]   rdata;
   logic [9:0]    free, thresh, exp_dw;
   logic [7:0]    cls;
   logic [2:0]    lat;
   bcdr_cfg_req_t req;
   logic [3:0]    lanes = 4'hF;
   int            errors = 0;
   int            n_tests = 0;
   // Clock at 50 MHz.
   always #10 clock = ~clock;
   bcdr_regs i_bcdr_regs (.CLOCK(clock), .RST_B(rst_b), .LINK_RESET_B(lrst_b),
      .GLOBAL_RESET_PIN_B(global_reset_pin_b), .CFG_REQ(req), .CFG_ACK(ack), .CFG_RDATA(rdata),
      .CACHE_LINE_SIZE(cls), .UP_FREE_DW(free), .UP_THRESH_DW(thresh), .UP_THRESH_EN(th_en),
      .UP_ACCEPT(accept), .CFG_MEM_ACCESS_EN(mem_en), .COMMON_CLOCK_CONFIG_BIT(ccc),
      .LINK_CAP_EXIT_LATENCY(lat), .SECONDARY_BUS_RESET_BIT(sbr), .SEC_BUS_RESET(sec),
      .LINK_IDLE(idle), .DEEP_IDLE_ENTRY_REQ(deep), .STANDBY_ENTRY_REQ(stby));
   // Compares one value and counts the outcome.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One access; the answer stands in the cycle after the request.
   task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
      @(negedge clock);
      req = '{1'b1, w, a, lanes, d};
      @(negedge clock);
      req.sel = 1'b0;
      check({31'h0, ack}, 32'h1);
      q = rdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      access(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      access(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog far beyond the roughly one hundred cycles the tests take.
   initial
   begin
      repeat (3000) @(posedge clock);
      errors++;
      tally_and_finish;
   end
   // Main test sequence.
   initial
   begin
      clock = 1'b0; rst_b = 1'b0; lrst_b = 1'b1; global_reset_pin_b = 1'b1; req = '0;
      cls = 8'h10; free = 10'h000; ccc = 1'b0; sbr = 1'b0; idle = 1'b0;
      repeat (3) @(negedge clock);
      rst_b = 1'b1;
      rd(BCDR_DIAG_OFFSET, DIAG_RESET);
      rd(BCDR_CTRL_OFFSET, CTRL_RESET);
      check({29'h0, lat}, 32'h4);
      check({30'h0, th_en, mem_en}, 32'h0);
      $display("test reset values done");
      wr(BCDR_CTRL_OFFSET, 32'hFFFF_FFFD);
      rd(BCDR_CTRL_OFFSET, 32'h0000_003C);
      check({30'h0, th_en, mem_en}, 32'h3);
      // A write with byte lane 0 disabled leaves the low byte alone.
      lanes = 4'hE;
      wr(BCDR_CTRL_OFFSET, 32'h0000_0000);
      lanes = 4'hF;
      rd(BCDR_CTRL_OFFSET, 32'h0000_003C);
      wr(BCDR_DIAG_OFFSET, 32'hFFFF_87FC);
      rd(BCDR_DIAG_OFFSET, 32'h001F_87FC);
      rd(8'hC8, 32'h0);
      $display("test access masks done");
      // Each threshold select with a 16 dword line, then an invalid line.
      for (int s = 0; s < 4; s++)
      begin
         wr(BCDR_CTRL_OFFSET, 32'h8 | (32'(s) << 4));
         repeat (2) @(negedge clock);
         exp_dw = (s == 3) ? 10'h024 : 10'h010 + 10'(4 * (s + 1));
         check({22'h0, thresh}, {22'h0, exp_dw});
         free = exp_dw - 10'h001;
         #1 check({31'h0, accept}, 32'h0);
         @(negedge clock);
         free = exp_dw;
         #1 check({31'h0, accept}, 32'h1);
      end
      cls = 8'h0C;
      wr(BCDR_CTRL_OFFSET, 32'h0000_0008);
      repeat (2) @(negedge clock);
      check({22'h0, thresh}, 32'd12);
      free = 10'd11;
      wr(BCDR_CTRL_OFFSET, 32'h0);
      check({31'h0, accept}, 32'h1);
      $display("test threshold done");
      wr(BCDR_DIAG_OFFSET, 32'h0015_0000);
      ccc = 1'b1;
      repeat (2) @(negedge clock);
      check({29'h0, lat}, 32'h5);
      ccc = 1'b0;
      repeat (2) @(negedge clock);
      check({29'h0, lat}, 32'h2);
      sbr = 1'b1;
      #1 check({31'h0, sec}, 32'h1);
      wr(BCDR_DIAG_OFFSET, 32'h0000_0400);
      check({31'h0, sec}, 32'h0);
      sbr = 1'b0;
      $display("test latency and reset block done");
      // Standby limit 3 cycles, deep idle limit 26 cycles.
      wr(BCDR_DIAG_OFFSET, 32'h0000_004C);
      idle = 1'b1;
      repeat (2) @(negedge clock);
      check({31'h0, stby}, 32'h0);
      @(negedge clock);
      check({31'h0, stby}, 32'h1);
      repeat (22) @(negedge clock);
      check({31'h0, deep}, 32'h0);
      @(negedge clock);
      check({31'h0, deep}, 32'h1);
      idle = 1'b0;
      #1 check({30'h0, deep, stby}, 32'h0);
      $display("test entry timers done");
      // Link reset, then global reset, restore the defaults.
      for (int k = 0; k < 2; k++)
      begin
         wr(BCDR_DIAG_OFFSET, 32'h0);
         wr(BCDR_CTRL_OFFSET, 32'h0000_003C);
         lrst_b = (k != 0);
         global_reset_pin_b = (k == 0);
         @(negedge clock);
         lrst_b = 1'b1;
         global_reset_pin_b = 1'b1;
         rd(BCDR_DIAG_OFFSET, DIAG_RESET);
         rd(BCDR_CTRL_OFFSET, CTRL_RESET);
      end
      $display("test field resets done");
      tally_and_finish;
   end
endmodule // tb_bcdr_regs
